/* File: core/ccrs_pkg.sv */
// Purpose: shared constants and carriers of the core clock ratio block
// Assumes: 32-bit AXI4-Lite register access, one 50 MHz input clock
// Notes: strap multipliers are plain defaults, adjust per product
package ccrs_pkg;
  // Register map, byte addresses
  localparam int ADDR_W = 4;
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STAT_OFS = 4'h4;
  // AXI response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  // Field widths
  localparam int MULT_W = 6;
  localparam int CTRL_W = 9;
  localparam int DCNT_W = 3;
  // Reset timing in input clock periods, CORE_SYNC_EDGES in core clock edges
  localparam int RST_HOLD_CYC = 4096;
  localparam int RST_HOLD_MAX = 4097;
  localparam int SYNC_DEPTH = 2;
  localparam int CORE_SYNC_EDGES = 2;
  // Multiplier chosen by the ratio pins, index = pin code
  localparam logic [3:0][MULT_W-1:0] STRAP_MULT =
    {6'h08, 6'h20, 6'h10, 6'h08};
  localparam logic [1:0] DIV_CODE_RST = 2'h0;
  localparam logic [3:0] DIV_ONE = 4'h1;

  typedef enum logic [1:0] {
    SEQ_HOLD = 2'b00,
    SEQ_COUNT = 2'b01,
    SEQ_SYNC = 2'b10,
    SEQ_RUN = 2'b11
  } ccrs_seq_t;

  // Control register layout: [8] input divide, [7:6] div, [5:0] mult
  typedef struct packed {
    logic input_divide_enable;
    logic [1:0] div_code;
    logic [MULT_W-1:0] mult;
  } ccrs_ctrl_t;

  localparam ccrs_ctrl_t CTRL_RST = '{1'h0, DIV_CODE_RST, 6'h08};

  // Settings handed to the analog loop
  typedef struct packed {
    logic [MULT_W-1:0] mult;
    logic [MULT_W:0] vco_mult;
    logic [3:0] div_val;
    logic input_divide_enable;
  } ccrs_pll_cfg_t;

  typedef struct packed {
    logic [DCNT_W-1:0] cnt;
    logic core;
    logic pclk;
  } ccrs_div_st_t;

  typedef struct packed {
    logic [1:0] rs;
    ccrs_seq_t seq;
    logic [12:0] cnt;
    logic [1:0] edges;
    logic rel;
    logic ref_ph;
    ccrs_ctrl_t ctrl;
    logic aw_h;
    logic [ADDR_W-1:0] aw_a;
    logic w_h;
    logic [31:0] w_d;
    logic [3:0] w_s;
    logic bv;
    logic [1:0] br;
    logic rv;
    logic [1:0] rr;
    logic [31:0] rd;
  } ccrs_st_t;
endpackage

/* File: core/ccrs_sync.sv */
// Purpose: two-stage synchroniser for pin levels
// Assumes: inputs are quasi-static levels
// Notes: no reset, so straps are already valid when reset lifts
module ccrs_sync #(
  parameter int W = 2
) (
  // Clock
  input wire logic clk,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [1:0][W-1:0] st_q;
  logic [1:0][W-1:0] st_d;

  always_comb begin
    st_d = {st_q[0], d};
  end

  always_ff @(posedge clk) begin
    st_q <= st_d;
  end

  assign q = st_q[1];
endmodule

/* File: core/ccrs_clkdiv.sv */
// Purpose: core and peripheral clock post-divider
// Assumes: vco_tick pulses once per oscillator period, same clock domain
// Notes: a new divider takes effect at once; the running half period ends at the new limit
module ccrs_clkdiv (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Oscillator and ratio
  input wire logic vco_tick,
  input wire logic [1:0] div_code,
  // Clocks out
  output logic core_clk,
  output logic core_rise,
  output logic periph_clk
);
  ccrs_pkg::ccrs_div_st_t st_q;
  ccrs_pkg::ccrs_div_st_t st_d;
  logic [ccrs_pkg::DCNT_W-1:0] lim;
  logic wrap;

  // Half period of D oscillator cycles gives a core period of 2*D
  assign lim = 3'((4'h1 << div_code) - 4'h1);
  assign wrap = vco_tick && (st_q.cnt >= lim);
  assign core_rise = wrap && !st_q.core;

  always_comb begin
    st_d = st_q;
    if (wrap) begin // see RL3
      st_d.cnt = '0;
      st_d.core = !st_q.core;
      if (!st_q.core) begin // see RL6
        st_d.pclk = !st_q.pclk;
      end
    end else if (vco_tick) begin
      st_d.cnt = st_q.cnt + 3'h1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign core_clk = st_q.core;
  assign periph_clk = st_q.pclk;

  AST_CORE_HALF: assert property ( // see RL3
    @(posedge clk) disable iff (!nrst)
    nrst && vco_tick && st_q.cnt == lim |=> core_clk != $past(core_clk))
    else $error("core clock did not toggle at divider end");

  AST_PCLK_HALF: assert property ( // see RL6
    @(posedge clk) disable iff (!nrst)
    $changed(periph_clk) |-> $rose(core_clk))
    else $error("peripheral clock moved off a core rising edge");
endmodule

/* File: core/ccrs_top.sv */
// Purpose: core clock ratio control and core reset sequencer
// Assumes: clk is the input clock pin, nrst the board reset pin
// Notes: analog loop is outside; it takes pll_cfg and pll_ref_en
// How it works
// RL1 - In reset multiplier comes from ratio pins, afterwards from software
// RL2 - Oscillator runs at twice multiplier times the loop input rate
// RL3 - Core clock is oscillator over 2*divider; divider 1,2,4,8, 1 in reset
// RL4 - Loop input is the input clock, halved when input divide is set
// RL5 - Software keeps input clock times multiplier within oscillator limits
// RL6 - Peripheral clock runs at half the core clock rate
// RL7 - Ratios are set by pins or by the software control register
// RL8 - Core reset held 4096 input clocks plus two core clocks
// RL9 - Late reset release may add one input clock, 4097 at most
// RL10 - Later resets hold the reset pin low at least four input clocks
// RL11 - Ratio pins stable 20 us before reset release
// RL12 - Input clock valid 10 us before reset release
// RL13 - Power-up reset low long enough for the loop to lock
// RL14 - Delay counts input clocks, then a two-edge core clock synchroniser
module ccrs_top #(
  parameter int RST_HOLD_CYC = ccrs_pkg::RST_HOLD_CYC
) (
  // Clock and reset pin
  input wire logic clk,
  input wire logic nrst,
  // Ratio straps and oscillator
  input wire logic [1:0] ratio_pins,
  input wire logic vco_tick,
  // AXI4-Lite write
  input wire logic [ccrs_pkg::ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [ccrs_pkg::ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Clocking out
  output ccrs_pkg::ccrs_pll_cfg_t pll_cfg,
  output logic pll_ref_en,
  output logic core_clk,
  output logic core_rise,
  output logic periph_clk,
  output logic core_rst_n
);
  localparam logic [12:0] CNT_END =
    13'(RST_HOLD_CYC - ccrs_pkg::SYNC_DEPTH - 1);
  localparam logic [1:0] EDGE_END = 2'(ccrs_pkg::CORE_SYNC_EDGES - 1);

  ccrs_pkg::ccrs_st_t st_q;
  ccrs_pkg::ccrs_st_t st_d;
  logic [1:0] strap;
  logic aw_fire;
  logic w_fire;
  logic ar_fire;
  logic wr_go;
  logic wr_ctrl;
  logic [31:0] rd_mux;
  logic [1:0] rd_resp;

  ccrs_sync #(
    .W(2)
  ) u_strap (
    .clk(clk),
    .d(ratio_pins),
    .q(strap)
  );

  ccrs_clkdiv u_div (
    .clk(clk),
    .nrst(nrst),
    .vco_tick(vco_tick),
    .div_code(st_q.ctrl.div_code),
    .core_clk(core_clk),
    .core_rise(core_rise),
    .periph_clk(periph_clk)
  );

  assign awready = !st_q.aw_h;
  assign wready = !st_q.w_h;
  assign arready = !st_q.rv;
  assign aw_fire = awvalid && awready;
  assign w_fire = wvalid && wready;
  assign ar_fire = arvalid && arready;
  assign wr_go = st_q.aw_h && st_q.w_h && !st_q.bv;
  // Ratio changes only once the core runs; straps own it before
  assign wr_ctrl = wr_go && st_q.aw_a[3:2] == ccrs_pkg::CTRL_OFS[3:2] &&
    st_q.seq == ccrs_pkg::SEQ_RUN;

  always_comb begin
    rd_mux = '0;
    rd_resp = ccrs_pkg::RESP_OKAY;
    case (araddr[3:2])
      ccrs_pkg::CTRL_OFS[3:2]: begin
        rd_mux[ccrs_pkg::CTRL_W-1:0] = st_q.ctrl;
      end
      ccrs_pkg::STAT_OFS[3:2]: begin
        rd_mux[4:0] = {strap, st_q.seq, st_q.rel};
      end
      default: begin
        rd_resp = ccrs_pkg::RESP_DECERR;
      end
    endcase
  end

  always_comb begin
    st_d = st_q;
    // Reset release synchroniser
    st_d.rs = {st_q.rs[0], 1'h1};
    // Loop input enable: every clock, or every other one
    st_d.ref_ph = st_q.ctrl.input_divide_enable ?
      !st_q.ref_ph : 1'h0; // see RL4
    case (st_q.seq)
      ccrs_pkg::SEQ_HOLD: begin
        st_d.ctrl = '{1'h0, ccrs_pkg::DIV_CODE_RST,
          ccrs_pkg::STRAP_MULT[strap]}; // see RL1
        if (st_q.rs[1]) begin
          st_d.seq = ccrs_pkg::SEQ_COUNT;
          st_d.cnt = '0;
        end
      end
      ccrs_pkg::SEQ_COUNT: begin
        st_d.cnt = st_q.cnt + 13'h1; // see RL14
        if (st_q.cnt == CNT_END) begin // see RL8
          st_d.seq = ccrs_pkg::SEQ_SYNC;
          st_d.edges = '0;
        end
      end
      ccrs_pkg::SEQ_SYNC: begin
        if (core_rise) begin // see RL14
          st_d.edges = st_q.edges + 2'h1;
          if (st_q.edges == EDGE_END) begin
            st_d.seq = ccrs_pkg::SEQ_RUN;
            st_d.rel = 1'h1;
          end
        end
      end
      ccrs_pkg::SEQ_RUN: begin
        st_d.rel = 1'h1;
      end
      default: begin
        st_d.seq = ccrs_pkg::SEQ_HOLD;
      end
    endcase
    // Write channels taken in either order
    if (aw_fire) begin
      st_d.aw_h = 1'h1;
      st_d.aw_a = awaddr;
    end
    if (w_fire) begin
      st_d.w_h = 1'h1;
      st_d.w_d = wdata;
      st_d.w_s = wstrb;
    end
    if (st_q.bv && bready) begin
      st_d.bv = 1'h0;
    end
    if (wr_go) begin
      st_d.aw_h = 1'h0;
      st_d.w_h = 1'h0;
      st_d.bv = 1'h1;
      st_d.br = ccrs_pkg::RESP_OKAY;
      if (wr_ctrl) begin // see RL7
        if (st_q.w_s[0]) begin
          st_d.ctrl[7:0] = st_q.w_d[7:0];
        end
        if (st_q.w_s[1]) begin
          st_d.ctrl.input_divide_enable = st_q.w_d[8];
        end
      end else if (st_q.aw_a[3:2] == ccrs_pkg::CTRL_OFS[3:2] ||
                   st_q.aw_a[3:2] == ccrs_pkg::STAT_OFS[3:2]) begin
        // Read-only status, or ratio locked during reset
        st_d.br = ccrs_pkg::RESP_SLVERR;
      end else begin
        st_d.br = ccrs_pkg::RESP_DECERR;
      end
    end
    if (st_q.rv && rready) begin
      st_d.rv = 1'h0;
    end
    if (ar_fire) begin
      st_d.rv = 1'h1;
      st_d.rd = rd_mux;
      st_d.rr = rd_resp;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= '{rs: 2'h0, seq: ccrs_pkg::SEQ_HOLD, cnt: 13'h0,
        edges: 2'h0, rel: 1'h0, ref_ph: 1'h0,
        ctrl: ccrs_pkg::CTRL_RST, aw_h: 1'h0, aw_a: 4'h0, w_h: 1'h0,
        w_d: 32'h0, w_s: 4'h0, bv: 1'h0, br: 2'h0, rv: 1'h0,
        rr: 2'h0, rd: 32'h0};
    end else begin
      st_q <= st_d;
    end
  end

  assign bvalid = st_q.bv;
  assign bresp = st_q.br;
  assign rvalid = st_q.rv;
  assign rresp = st_q.rr;
  assign rdata = st_q.rd;
  assign core_rst_n = st_q.rel;
  assign pll_ref_en = !st_q.ref_ph;
  // Divider one until release; straps steer the loop so it locks in reset
  always_comb begin
    pll_cfg.mult = st_q.ctrl.mult;
    if (st_q.seq == ccrs_pkg::SEQ_HOLD) begin // see RL1
      pll_cfg.mult = ccrs_pkg::STRAP_MULT[strap];
    end
    pll_cfg.vco_mult = {pll_cfg.mult, 1'h0}; // see RL2
    pll_cfg.div_val = st_q.rel ?
      4'(4'h1 << st_q.ctrl.div_code) : ccrs_pkg::DIV_ONE; // see RL3
    pll_cfg.input_divide_enable = st_q.ctrl.input_divide_enable;
  end

  // Helper: cycles spent counting input clocks
  logic [12:0] hc_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hc_q <= 13'h0;
    end else if (st_q.seq == ccrs_pkg::SEQ_COUNT) begin
      hc_q <= hc_q + 13'h1;
    end
  end

  AST_STRAP_LOAD: assert property ( // see RL1
    @(posedge clk) disable iff (!nrst)
    nrst && st_q.seq == ccrs_pkg::SEQ_HOLD |=>
      st_q.ctrl.mult == ccrs_pkg::STRAP_MULT[$past(strap)])
    else $error("multiplier not taken from ratio pins in reset");

  AST_SW_MULT: assert property ( // see RL1
    @(posedge clk) disable iff (!nrst)
    wr_ctrl && st_q.w_s[0] |=> pll_cfg.mult == $past(st_q.w_d[5:0]))
    else $error("software multiplier not applied");

  AST_VCO_MULT: assert property ( // see RL2
    @(posedge clk) disable iff (!nrst)
    $changed(st_q.ctrl.mult) |-> pll_cfg.vco_mult == 7'(2 * pll_cfg.mult))
    else $error("oscillator ratio is not twice the multiplier");

  AST_DIV_RESET: assert property ( // see RL3
    @(posedge clk) disable iff (!nrst)
    !core_rst_n |-> pll_cfg.div_val == 4'h1)
    else $error("divider not one during reset");

  AST_SW_DIV: assert property ( // see RL7
    @(posedge clk) disable iff (!nrst)
    wr_ctrl && st_q.w_s[0] |=>
      pll_cfg.div_val == 4'(4'h1 << $past(st_q.w_d[7:6])))
    else $error("software divider not applied");

  AST_REF_HALF: assert property ( // see RL4
    @(posedge clk) disable iff (!nrst)
    pll_cfg.input_divide_enable && $past(pll_cfg.input_divide_enable) &&
      pll_ref_en |=> !pll_ref_en)
    else $error("loop input not halved");

  AST_REF_FULL: assert property ( // see RL4
    @(posedge clk) disable iff (!nrst)
    !pll_cfg.input_divide_enable ##1 !pll_cfg.input_divide_enable |->
      pll_ref_en)
    else $error("loop input missing a clock");

  AST_HOLD_LEN: assert property ( // see RL8
    @(posedge clk) disable iff (!nrst)
    st_q.seq == ccrs_pkg::SEQ_SYNC && $past(st_q.seq) ==
      ccrs_pkg::SEQ_COUNT |-> hc_q == 13'(CNT_END + 13'h1))
    else $error("core reset counter length wrong");

  AST_HOLD_MAX: assert property ( // see RL9
    @(posedge clk) disable iff (!nrst)
    hc_q <= 13'(ccrs_pkg::RST_HOLD_MAX))
    else $error("core reset counting beyond its maximum");

  AST_CORE_SYNC: assert property ( // see RL14
    @(posedge clk) disable iff (!nrst)
    $rose(core_rst_n) |-> $past(core_rise) && $past(st_q.edges) == EDGE_END)
    else $error("core reset released off the core clock");

  AST_CTRL_LOCKED: assert property ( // see RL1
    @(posedge clk) disable iff (!nrst)
    nrst && wr_go && st_q.seq != ccrs_pkg::SEQ_RUN |=>
      bresp != ccrs_pkg::RESP_OKAY)
    else $error("ratio write accepted before core release");

  AST_REL_STAYS: assert property ( // see RL8
    @(posedge clk) disable iff (!nrst)
    core_rst_n |=> core_rst_n)
    else $error("core reset asserted again without the pin");

  AST_DIV_ONEHOT: assert property ( // see RL3
    @(posedge clk) disable iff (!nrst)
    $onehot(pll_cfg.div_val))
    else $error("divider outside one, two, four and eight");
endmodule

/* File: testbench/ccrs_src_model.sv */
// Purpose: input clock side partner: reset pin and oscillator ticks
// Assumes: clk runs free, also while the reset pin is low
// Notes: tick spacing is gap+1 input clocks, set by the bench
module ccrs_src_model (
  // Clock
  input wire logic clk,
  // Bench control
  input wire logic rst_req,
  input wire logic [1:0] gap,
  // Toward the block
  output logic nrst,
  output logic vco_tick
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] low_q;
  logic [1:0] tick_q;
  initial begin
    nrst = 1'h0;
    vco_tick = 1'h0;
    low_q = 3'h0;
    tick_q = 2'h0;
  end
  // Pin stays low five input clocks past any request
  // Clock keeps running while the pin is low
  always @(posedge clk) begin
    if (rst_req) begin
      nrst <= 1'h0;
      low_q <= 3'h0;
    end else if (low_q < 3'h4) begin
      low_q <= low_q + 3'h1;
    end else begin
      nrst <= 1'h1;
    end
  end
  // Steady oscillator pulse train
  always @(posedge clk) begin
    if (tick_q >= gap) begin
      vco_tick <= 1'h1;
      tick_q <= 2'h0;
    end else begin
      vco_tick <= 1'h0;
      tick_q <= tick_q + 2'h1;
    end
  end
endmodule

/* File: testbench/tb.sv */
// Purpose: self-checking bench of the clock ratio and reset sequencer
// Assumes: short reset hold count so each reset takes few cycles
// Notes: bus results are queued by the drivers and checked by a watcher
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HOLD = 16;
  logic clk = 1'h0;
  logic rst_req, nrst, vco_tick, core_clk, core_rise, periph_clk;
  logic core_rst_n, pll_ref_en;
  logic [1:0] gap, ratio_pins, bresp, rresp;
  logic [3:0] awaddr, araddr, wstrb;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  ccrs_pkg::ccrs_pll_cfg_t pll_cfg;
  logic [1:0] exp_b[$];
  logic [34:0] exp_r[$];
  logic [34:0] e;
  int miscompares = 0, checks_done = 0, rcnt = 0, ecount, rises;
  logic [5:0] strap[4] = '{6'h08, 6'h10, 6'h20, 6'h08};

  always #10 clk = ~clk;

  ccrs_src_model ccrs_src_model_i (.clk(clk), .rst_req(rst_req),
    .gap(gap), .nrst(nrst), .vco_tick(vco_tick));
  ccrs_top #(.RST_HOLD_CYC(HOLD)) ccrs_top_i (.clk(clk), .nrst(nrst),
    .ratio_pins(ratio_pins), .vco_tick(vco_tick), .awaddr(awaddr),
    .awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .pll_cfg(pll_cfg),
    .pll_ref_en(pll_ref_en), .core_clk(core_clk), .core_rise(core_rise),
    .periph_clk(periph_clk), .core_rst_n(core_rst_n));

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    checks_done++;
    if (g !== x) begin
      miscompares++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, x);
    end
  endtask

  task automatic conclude();
    if (exp_b.size() + exp_r.size() > 0) miscompares++;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Results are matched oldest first as they appear
  always @(posedge clk) begin
    if (bvalid === 1'h1 && bready === 1'h1 && exp_b.size() > 0)
      chk({30'h0, bresp}, {30'h0, exp_b.pop_front()});
    if (rvalid === 1'h1 && rready === 1'h1 && exp_r.size() > 0) begin
      e = exp_r.pop_front();
      chk({30'h0, rresp}, {30'h0, e[33:32]});
      if (e[34]) chk(rdata, e[31:0]);
    end
  end

  // Cycles from pin release to core reset release
  always @(posedge clk) begin
    if (nrst !== 1'h1) rcnt <= 0;
    else if (core_rst_n !== 1'h1) rcnt <= rcnt + 1;
  end

  task automatic axw(input logic [3:0] a, input logic [31:0] d,
                     input logic [1:0] er);
    int n = 0;
    exp_b.push_back(er);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge clk);
      if (awready === 1'h1) awvalid <= 1'h0;
      if (wready === 1'h1) wvalid <= 1'h0;
      n++;
    end while (bvalid !== 1'h1 && n < 50);
    bready <= 1'h0;
    @(posedge clk);
  endtask

  // cd low skips the data check, for refused reads
  task automatic axr(input logic [3:0] a, input logic [31:0] d,
                     input logic [1:0] er, input logic cd);
    int n = 0;
    exp_r.push_back({cd, er, d});
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge clk);
      if (arready === 1'h1) arvalid <= 1'h0;
      n++;
    end while (rvalid !== 1'h1 && n < 50);
    rready <= 1'h0;
    @(posedge clk);
  endtask

  task automatic do_rst(input logic [1:0] p);
    int k = 0;
    gap <= 2'h0;
    rst_req <= 1'h1;
    ratio_pins <= p;
    repeat (16) @(posedge clk);
    chk({31'h0, core_rst_n}, 32'h0);
    chk({26'h0, pll_cfg.mult}, {26'h0, strap[p]});
    chk({28'h0, pll_cfg.div_val}, 32'h1);
    rst_req <= 1'h0;
    while (nrst !== 1'h1 && k < 20) begin @(posedge clk); k++; end
    axw(ccrs_pkg::CTRL_OFS, 32'h1FF, ccrs_pkg::RESP_SLVERR);
    while (core_rst_n !== 1'h1 && k < 400) begin @(posedge clk); k++; end
    if (k >= 400) miscompares++;
    chk({26'h0, pll_cfg.mult}, {26'h0, strap[p]});
    chk({25'h0, pll_cfg.vco_mult}, {25'h0, strap[p], 1'h0});
    chk({31'h0, rcnt >= HOLD + 2 && rcnt <= HOLD + 8}, 32'h1);
    axr(ccrs_pkg::STAT_OFS, {27'h0, p, 3'h7}, ccrs_pkg::RESP_OKAY, 1'h1);
    $display("test reset pins %0d done", p);
  endtask

  task automatic wait_lvl(input logic v);
    int k = 0;
    while (periph_clk !== v && k < 400) begin
      @(posedge clk);
      k++;
      ecount++;
      if (core_rise === 1'h1) rises++;
    end
    if (k >= 400) miscompares++;
  endtask

  initial begin
    int n;
    logic [5:0] m;
    logic [1:0] g;
    {awaddr, araddr, wstrb, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    void'($urandom(32'hDDA8));
    for (int p = 0; p < 4; p++) do_rst(p[1:0]);
    for (int c = 0; c < 4; c++) begin
      for (int iv = 0; iv < 2; iv++) begin
        m = 6'($urandom_range(1, 32));
        g = 2'($urandom_range(0, 2));
        gap <= g;
        axw(ccrs_pkg::CTRL_OFS, {23'h0, iv[0], c[1:0], m},
            ccrs_pkg::RESP_OKAY);
        axr(ccrs_pkg::CTRL_OFS, {23'h0, iv[0], c[1:0], m},
            ccrs_pkg::RESP_OKAY, 1'h1);
        chk({pll_cfg.mult, pll_cfg.vco_mult, pll_cfg.input_divide_enable},
            {m, m, 1'h0, iv[0]});
        chk({28'h0, pll_cfg.div_val}, 32'h1 << c);
        wait_lvl(1'h0);
        wait_lvl(1'h1);
        ecount = 0;
        rises = 0;
        wait_lvl(1'h0);
        wait_lvl(1'h1);
        chk(ecount, (4 << c) * (g + 1));
        chk(rises, 2);
        n = 0;
        repeat (16) begin
          @(posedge clk);
          if (pll_ref_en === 1'h1) n++;
        end
        chk(n, iv ? 8 : 16);
        $display("test ratio %0d input_divide_enable %0d done", c, iv);
      end
    end
    axw(ccrs_pkg::STAT_OFS, 32'h0, ccrs_pkg::RESP_SLVERR);
    axw(4'h8, 32'h0, ccrs_pkg::RESP_DECERR);
    axr(4'h8, 32'h0, ccrs_pkg::RESP_DECERR, 1'h0);
    $display("test refused accesses done");
    do_rst(2'($urandom_range(0, 3)));
    conclude();
  end

  // Run should end well inside this span
  initial begin
    #400000;
    miscompares++;
    conclude();
  end
endmodule
